/* File: core/mzc_cfg.svh */
// Timing, size and encoding constants for the mezzanine carrier port.
// Included by the package, mzc_busclk and mzc_carrier; definitions only.
`ifndef MZC_CFG_SVH
`define MZC_CFG_SVH

`define MZC_CLK_MHZ 125
`define MZC_BUS_MHZ 8
`define MZC_ACC_W 8
`define MZC_SLOTS 4
`define MZC_DATA_W 16
`define MZC_ADDR_W 6
`define MZC_ID_BYTES 32
`define MZC_ACK_TMO 64
`define MZC_TMO_W 8
`define MZC_WAIT_W 12
`define MZC_RST_HOLD 8
`define MZC_STROBE_IDLE 4'hF
`define MZC_SLOT_ONE 4'h1
`define MZC_BE_WORD 2'h3
`define MZC_SYNC_W 41

`endif

/* File: core/mzc_pkg.sv */
// Types shared by the carrier port and its user-side logic.
// Assumes mzc_cfg.svh is on the include path.
`include "mzc_cfg.svh"

package mzc_pkg;

  // Address space of one bus cycle; DMA uses the shared grant, no strobe
  typedef enum logic [2:0] {
    MZC_SP_ID  = 3'h0,
    MZC_SP_MEM = 3'h1,
    MZC_SP_VEC = 3'h2,
    MZC_SP_IO  = 3'h3,
    MZC_SP_DMA = 3'h4
  } mzc_space_t;

  typedef enum logic [3:0] {
    MZC_ST_IDLE  = 4'h1,
    MZC_ST_SETUP = 4'h2,
    MZC_ST_WAIT  = 4'h4,
    MZC_ST_END   = 4'h8
  } mzc_state_t;

  typedef struct packed {
    mzc_space_t space;
    logic [1:0] slot;
    logic [`MZC_ADDR_W-1:0] addr;
    logic write;
    logic [1:0] be;
    logic [`MZC_DATA_W-1:0] wdata;
  } mzc_req_t;

  typedef struct packed {
    logic [`MZC_DATA_W-1:0] rdata;
    logic timeout;
    logic terminated;
    logic write;
  } mzc_rsp_t;

endpackage

/* File: core/mzc_sync.sv */
// Two-flop level synchroniser for pins arriving from the module slots.
// Assumes the inputs are quasi-static relative to the local clock.
module mzc_sync #(
  parameter int W = 1
) (
  input wire logic clock, // local clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: core/mzc_busclk.sv */
// Bus clock generator: phase accumulator dividing the local clock.
// Assumes CLK_MHZ is not an even multiple of BUS_MHZ; the average rate
// is exact, single half periods differ by one local cycle.
`include "mzc_cfg.svh"
module mzc_busclk #(
  parameter int CLK_MHZ = `MZC_CLK_MHZ,
  parameter int BUS_MHZ = `MZC_BUS_MHZ,
  parameter int ACC_W = `MZC_ACC_W
) (
  input wire logic clock, // local clock
  input wire logic rst_n, // async reset, active low
  output logic bus_clk, // generated bus clock level
  output logic rise, // pulse with bus clock going high
  output logic fall // pulse with bus clock going low
);
  localparam logic [ACC_W-1:0] INC = ACC_W'(2 * BUS_MHZ);
  localparam logic [ACC_W-1:0] MODV = ACC_W'(CLK_MHZ);

  logic [ACC_W-1:0] acc_r;
  wire [ACC_W-1:0] acc_sum = acc_r + INC;
  wire wrap = acc_sum >= MODV;
  wire [ACC_W-1:0] acc_nxt = wrap ? acc_sum - MODV : acc_sum;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= '0;
      bus_clk <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      bus_clk <= bus_clk ^ wrap;
      rise <= wrap & ~bus_clk;
      fall <= wrap & bus_clk;
    end
  end
endmodule

/* File: core/mzc_carrier.sv */
// Carrier end of the mezzanine I/O port: one cycle engine serving up to
// four slots. Assumes user requests come from logic on the same clock
// and that every slot pin arrives asynchronously.
//
// Overview of operation
// - Free-running 8 MHz bus clock, transfers synchronous
// - Active-low reset halts module activity
// - Shared 16-bit bidirectional data bus
// - Byte enables qualify low, high byte
// - Direction high read, low write
// - Identity strobe reads 32-byte identity memory
// - Separate strobe copies for every slot
// - Memory strobe for memory cycles
// - Vector strobe reads interrupt vector
// - I/O strobe for input, output cycles
// - One shared active-low DMA grant qualifier
// - Second DMA grant never driven
// - Either end may assert DMA terminate
// - Six address lines starting at bit one
// - Four identical slots supported together
`include "mzc_cfg.svh"
module mzc_carrier #(
  parameter int SLOTS = `MZC_SLOTS,
  parameter int ACK_TMO = `MZC_ACK_TMO,
  parameter int RST_HOLD = `MZC_RST_HOLD
) (
  input wire logic clock, // 125 MHz local clock
  input wire logic rst_n, // async reset, active low
  input wire logic req_valid, // cycle request present
  input wire mzc_pkg::mzc_req_t req, // cycle request
  output logic req_ready, // request taken when high with valid
  output logic rsp_valid, // one-cycle answer strobe
  output mzc_pkg::mzc_rsp_t rsp, // answer of the last cycle
  input wire logic dma_end_assert, // carrier asserts DMA terminate
  output logic dma_end_seen, // terminate line seen low
  output logic [SLOTS-1:0] svc_req0, // slot service request 0
  output logic [SLOTS-1:0] svc_req1, // slot service request 1
  output logic [SLOTS-1:0] fault, // slot fatal error
  output logic [SLOTS-1:0] dma_pend0, // slot DMA channel 0 request
  output logic [SLOTS-1:0] dma_pend1, // slot DMA channel 1 request
  output logic bus_clock_out, // bus clock to all slots
  output logic bus_reset_n, // bus reset, active low
  input wire logic [`MZC_DATA_W-1:0] shared_data_lines_i, // data in
  output logic [`MZC_DATA_W-1:0] shared_data_lines_o, // data out
  output logic shared_data_lines_oe_n, // data drive, low drives
  output logic low_byte_enable_n, // low byte qualifier
  output logic high_byte_enable_n, // high byte qualifier
  output logic read_not_write, // high read, low write
  output logic [`MZC_ADDR_W:1] module_address, // address bits 6..1
  output logic [SLOTS-1:0] identity_space_strobe_n, // identity space
  output logic [SLOTS-1:0] memory_space_strobe_n, // memory space
  output logic [SLOTS-1:0] vector_fetch_strobe_n, // vector fetch
  output logic [SLOTS-1:0] io_space_strobe_n, // I/O space
  output logic dma_grant_qualifier_n, // shared DMA grant
  input wire logic dma_terminate_n_i, // terminate line level
  output logic dma_terminate_n_o, // terminate drive value
  output logic dma_terminate_n_oe_n, // terminate drive, low drives
  input wire logic [SLOTS-1:0] dma_request_ch0, // DMA request ch 0
  input wire logic [SLOTS-1:0] dma_request_ch1, // DMA request ch 1
  input wire logic [SLOTS-1:0] service_request0_n, // service req 0
  input wire logic [SLOTS-1:0] service_request1_n, // service req 1
  input wire logic [SLOTS-1:0] module_error_n, // fatal error
  input wire logic [SLOTS-1:0] module_ack_n // transfer acknowledge
);
  import mzc_pkg::*;

  // ----------------------------------------------------------------
  // Bus clock and pin synchronisers
  // ----------------------------------------------------------------
  logic rise_tick;
  logic fall_tick;
  logic [`MZC_SYNC_W-1:0] sync_q;

  mzc_busclk #(
    .CLK_MHZ(`MZC_CLK_MHZ),
    .BUS_MHZ(`MZC_BUS_MHZ),
    .ACC_W(`MZC_ACC_W)
  ) u_busclk (
    .clock(clock),
    .rst_n(rst_n),
    .bus_clk(bus_clock_out),
    .rise(rise_tick),
    .fall(fall_tick)
  );

  // Active-low pins inverted ahead of the first flop only
  mzc_sync #(.W(`MZC_SYNC_W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({~module_ack_n, shared_data_lines_i, ~dma_terminate_n_i,
        dma_request_ch0, dma_request_ch1, ~service_request0_n,
        ~service_request1_n, ~module_error_n}),
    .q(sync_q)
  );

  wire [SLOTS-1:0] ack_s = sync_q[40:37];
  wire [`MZC_DATA_W-1:0] rdata_s = sync_q[36:21];
  wire term_s = sync_q[20];

  // Status levels reach the user straight from the second flop
  assign dma_pend0 = sync_q[19:16];
  assign dma_pend1 = sync_q[15:12];
  assign svc_req0 = sync_q[11:8];
  assign svc_req1 = sync_q[7:4];
  assign fault = sync_q[3:0];

  // ----------------------------------------------------------------
  // Bus reset
  // ----------------------------------------------------------------
  logic [`MZC_TMO_W-1:0] rst_cnt_r;
  wire rst_done = rst_cnt_r == `MZC_TMO_W'(RST_HOLD);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_cnt_r <= '0;
      bus_reset_n <= 1'b0;
    end
    else
    begin
      if (rise_tick && !rst_done)
        rst_cnt_r <= rst_cnt_r + 1'b1;
      bus_reset_n <= rst_done;
    end
  end

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  mzc_state_t state_r;
  mzc_state_t state_nxt;
  mzc_req_t cur_r;
  logic [`MZC_TMO_W-1:0] tmo_r;

  wire [SLOTS-1:0] slot_sel = `MZC_SLOT_ONE << cur_r.slot;
  wire is_dma = cur_r.space == MZC_SP_DMA;
  // Identity and vector spaces are read-only
  wire rd_only = cur_r.space == MZC_SP_ID
              || cur_r.space == MZC_SP_VEC;
  wire cyc_read = rd_only || !cur_r.write;
  wire [1:0] be_lo = cyc_read ? `MZC_BE_WORD : cur_r.be;
  wire ack_hit = |(ack_s & slot_sel) || (is_dma && term_s);
  wire tmo_hit = tmo_r == `MZC_TMO_W'(ACK_TMO - 1);
  wire launch = state_r == MZC_ST_SETUP && fall_tick;
  wire sample = state_r == MZC_ST_WAIT && rise_tick;
  wire finish = state_r == MZC_ST_END && fall_tick;

  // One strobe per cycle, one slot per cycle
  wire [SLOTS-1:0] id_sel = cur_r.space == MZC_SP_ID ? slot_sel : '0;
  wire [SLOTS-1:0] mem_sel = cur_r.space == MZC_SP_MEM ? slot_sel : '0;
  wire [SLOTS-1:0] vec_sel = cur_r.space == MZC_SP_VEC ? slot_sel : '0;
  wire [SLOTS-1:0] io_sel = cur_r.space == MZC_SP_IO ? slot_sel : '0;
  // No second grant line exists; that pin is left unconnected.

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MZC_ST_IDLE:
        if (req_valid && req_ready)
          state_nxt = MZC_ST_SETUP;
      MZC_ST_SETUP:
        if (fall_tick)
          state_nxt = MZC_ST_WAIT;
      MZC_ST_WAIT:
        if (rise_tick && (ack_hit || tmo_hit))
          state_nxt = MZC_ST_END;
      MZC_ST_END:
        if (fall_tick)
          state_nxt = MZC_ST_IDLE;
      default:
        state_nxt = MZC_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Cycle engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= MZC_ST_IDLE;
      cur_r <= '0;
      tmo_r <= '0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      req_ready <= state_nxt == MZC_ST_IDLE && rst_done;
      rsp_valid <= finish;
      if (req_valid && req_ready)
        cur_r <= req;
      if (launch)
        tmo_r <= '0;
      else if (sample)
        tmo_r <= tmo_r + 1'b1;
      if (sample && (ack_hit || tmo_hit))
      begin
        // Unanswered reads give zero, never a floating bus
        rsp.rdata <= cyc_read && ack_hit ? rdata_s : '0;
        rsp.timeout <= !ack_hit;
        rsp.terminated <= is_dma && term_s;
        rsp.write <= !cyc_read;
      end
    end
  end

  // Pins change only on bus clock falls; held through the wait
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      identity_space_strobe_n <= `MZC_STROBE_IDLE;
      memory_space_strobe_n <= `MZC_STROBE_IDLE;
      vector_fetch_strobe_n <= `MZC_STROBE_IDLE;
      io_space_strobe_n <= `MZC_STROBE_IDLE;
      dma_grant_qualifier_n <= 1'b1;
      read_not_write <= 1'b1;
      low_byte_enable_n <= 1'b1;
      high_byte_enable_n <= 1'b1;
      module_address <= '0;
      shared_data_lines_o <= '0;
      shared_data_lines_oe_n <= 1'b1;
    end
    else if (launch)
    begin
      identity_space_strobe_n <= ~id_sel;
      memory_space_strobe_n <= ~mem_sel;
      vector_fetch_strobe_n <= ~vec_sel;
      io_space_strobe_n <= ~io_sel;
      dma_grant_qualifier_n <= ~is_dma;
      read_not_write <= cyc_read;
      low_byte_enable_n <= ~be_lo[0];
      high_byte_enable_n <= ~be_lo[1];
      module_address <= cur_r.addr;
      shared_data_lines_o <= cur_r.wdata;
      shared_data_lines_oe_n <= cyc_read;
    end
    else if (finish)
    begin
      identity_space_strobe_n <= `MZC_STROBE_IDLE;
      memory_space_strobe_n <= `MZC_STROBE_IDLE;
      vector_fetch_strobe_n <= `MZC_STROBE_IDLE;
      io_space_strobe_n <= `MZC_STROBE_IDLE;
      dma_grant_qualifier_n <= 1'b1;
      read_not_write <= 1'b1;
      low_byte_enable_n <= 1'b1;
      high_byte_enable_n <= 1'b1;
      shared_data_lines_oe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // DMA terminate, open drain
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma_terminate_n_o <= 1'b0;
      dma_terminate_n_oe_n <= 1'b1;
      dma_end_seen <= 1'b0;
    end
    else
    begin
      dma_terminate_n_o <= 1'b0;
      dma_terminate_n_oe_n <= ~dma_end_assert;
      dma_end_seen <= term_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int HALF_MIN = `MZC_CLK_MHZ / (2 * `MZC_BUS_MHZ);
  localparam int HALF_MAX = HALF_MIN + 1;
  localparam int WAIT_MAX = (ACK_TMO + 1) * 2 * HALF_MAX;
  logic [`MZC_TMO_W-1:0] hi_cnt_r;
  logic [`MZC_WAIT_W-1:0] wait_cnt_r;
  wire [4*SLOTS-1:0] all_strb_lo = ~{identity_space_strobe_n,
    memory_space_strobe_n, vector_fetch_strobe_n, io_space_strobe_n};

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_cnt_r <= '0;
      wait_cnt_r <= '0;
    end
    else
    begin
      hi_cnt_r <= bus_clock_out ? hi_cnt_r + 1'b1 : '0;
      wait_cnt_r <= state_r == MZC_ST_WAIT ? wait_cnt_r + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_busclk_high_phase: assert property (
    fall_tick |-> hi_cnt_r >= HALF_MIN && hi_cnt_r <= HALF_MAX)
    else $error("bus clock high phase out of range");
  a_reset_no_strobe: assert property (
    !bus_reset_n |-> &{identity_space_strobe_n, memory_space_strobe_n,
      vector_fetch_strobe_n, io_space_strobe_n, dma_grant_qualifier_n})
    else $error("strobe active during bus reset");
  a_write_drives_bus: assert property (
    $fell(shared_data_lines_oe_n) |-> !read_not_write && $past(launch))
    else $error("data bus driven outside a write launch");
  a_read_both_bytes: assert property (
    read_not_write && $rose(|all_strb_lo)
      |-> !low_byte_enable_n && !high_byte_enable_n)
    else $error("read cycle without both byte enables");
  a_read_releases_bus: assert property (
    read_not_write |-> shared_data_lines_oe_n)
    else $error("carrier drives data in a read cycle");
  a_identity_read_only: assert property (
    |(~identity_space_strobe_n) |-> read_not_write)
    else $error("write issued to identity space");
  a_one_strobe_only: assert property (
    $onehot0(all_strb_lo) && !(!dma_grant_qualifier_n && |all_strb_lo))
    else $error("more than one select active");
  a_cycle_stable: assert property (
    state_r == MZC_ST_WAIT && $past(state_r) == MZC_ST_WAIT |->
      $stable(module_address) && $stable(read_not_write)
      && $stable(all_strb_lo) && $stable(low_byte_enable_n))
    else $error("cycle signals moved before acknowledge");
  a_ack_ends_cycle: assert property (
    sample && ack_hit |=> state_r == MZC_ST_END ##[1:20] rsp_valid
      && !rsp.timeout)
    else $error("acknowledged cycle did not complete");
  a_unanswered_bounded: assert property (
    state_r == MZC_ST_WAIT |-> wait_cnt_r <= WAIT_MAX)
    else $error("cycle hung without acknowledge or timeout");
  a_terminate_drive: assert property (
    dma_end_assert |=> !dma_terminate_n_oe_n && !dma_terminate_n_o)
    else $error("terminate line not driven low");

  c_write_cycle: cover property (rsp_valid && rsp.write);
  c_vector_read: cover property (launch && cur_r.space == MZC_SP_VEC);
  c_timeout: cover property (rsp_valid && rsp.timeout);
  c_dma_terminated: cover property (rsp_valid && rsp.terminated);
endmodule

/* File: bench/mzc_slot_model.sv */
// Behavioural model of the plug-in modules in all four slots.
// Assumes it watches the carrier's bus pins directly; ack and data
// are launched from bus clock falls, well before the carrier samples.
module mzc_slot_model (
  input wire logic bus_clk, // bus clock from the carrier
  input wire logic rnw, // high read, low write
  input wire logic [6:1] addr, // address lines
  input wire logic [15:0] stb_n, // io, vec, mem, id strobes
  input wire logic grant_n, // shared DMA grant
  input wire logic [3:0] mute, // slots that never answer
  input wire logic [1:0] dma_slot, // slot serving DMA
  input wire logic term_mode, // end DMA by terminate, not ack
  output logic [3:0] ack_n, // acknowledge per slot
  output logic [15:0] data, // data lines from the modules
  output logic term_pull // module pulls terminate low
);
  logic [3:0] sel;
  logic [1:0] sp;
  logic [1:0] sl;
  logic [3:0] cnt = 4'h0;
  logic [15:0] last = 16'h0000;
  logic busy;

  always_comb
  begin
    sel = 4'h0;
    sp = 2'h0;
    sl = dma_slot;
    for (int i = 0; i < 16; i++)
      if (!stb_n[i])
      begin
        sel[i % 4] = 1'b1;
        sp = 2'(i / 4);
        sl = 2'(i % 4);
      end
    if (!grant_n && !term_mode)
      sel[dma_slot] = 1'b1;
  end

  assign busy = (sel != 4'h0) || !grant_n;

  // Slot n answers after n+1 bus falls: prompt and slow modules alike
  always @(negedge bus_clk)
  begin
    cnt <= busy ? cnt + 4'h1 : 4'h0;
    last <= data;
  end

  assign ack_n = ~(sel & ~mute & {4{cnt > {2'h0, sl}}});
  // Released bus toggles so a stale value never passes for read data
  assign data = (busy && rnw) ? {4'hC, sl, sp, 2'h0, addr} : ~last;
  assign term_pull = !grant_n && term_mode && cnt > 4'h1;
endmodule

/* File: bench/test_mezzanine_io_carrier_port.sv */
// Self-checking bench for the carrier port with four modelled slots.
// Assumes mzc_cfg.svh on the include path and a pull-up on terminate.
module test_mezzanine_io_carrier_port;
  timeunit 1ns;
  timeprecision 1ps;
  import mzc_pkg::*;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  mzc_req_t req = '0;
  logic dma_end_assert = 1'b0;
  logic [3:0] dreq0 = 4'h0, dreq1 = 4'h0, err_n = 4'hF;
  logic [3:0] svc0_n = 4'hF, svc1_n = 4'hF, mute = 4'h0;
  logic [1:0] dma_slot = 2'h0;
  logic term_mode = 1'b0;
  logic req_ready, rsp_valid, dma_end_seen, bus_clock_out, bus_reset_n;
  mzc_rsp_t rsp;
  logic [3:0] svc_req0, svc_req1, fault, dma_pend0, dma_pend1;
  logic [15:0] d_i, d_o, m_data;
  logic d_oe_n, be_lo_n, be_hi_n, rnw, grant_n, t_o, t_oe_n, m_pull;
  logic [6:1] addr;
  logic [3:0] id_n, mem_n, vec_n, io_n, ack_n;
  wire logic [15:0] stb_n = {io_n, vec_n, mem_n, id_n};
  int mismatches = 0;
  int cmp_count = 0;

  always #4 clock = ~clock;

  assign d_i = d_oe_n ? m_data : d_o;

  mzc_carrier #(.ACK_TMO(8), .RST_HOLD(2)) u_dut (
    .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .dma_end_assert(dma_end_assert), .dma_end_seen(dma_end_seen),
    .svc_req0(svc_req0), .svc_req1(svc_req1), .fault(fault),
    .dma_pend0(dma_pend0), .dma_pend1(dma_pend1),
    .bus_clock_out(bus_clock_out), .bus_reset_n(bus_reset_n),
    .shared_data_lines_i(d_i), .shared_data_lines_o(d_o),
    .shared_data_lines_oe_n(d_oe_n), .low_byte_enable_n(be_lo_n),
    .high_byte_enable_n(be_hi_n), .read_not_write(rnw),
    .module_address(addr), .identity_space_strobe_n(id_n),
    .memory_space_strobe_n(mem_n), .vector_fetch_strobe_n(vec_n),
    .io_space_strobe_n(io_n), .dma_grant_qualifier_n(grant_n),
    .dma_terminate_n_i(!((!t_oe_n && !t_o) || m_pull)),
    .dma_terminate_n_o(t_o), .dma_terminate_n_oe_n(t_oe_n),
    .dma_request_ch0(dreq0), .dma_request_ch1(dreq1),
    .service_request0_n(svc0_n), .service_request1_n(svc1_n),
    .module_error_n(err_n), .module_ack_n(ack_n)
  );

  mzc_slot_model u_model (
    .bus_clk(bus_clock_out), .rnw(rnw), .addr(addr), .stb_n(stb_n),
    .grant_n(grant_n), .mute(mute), .dma_slot(dma_slot),
    .term_mode(term_mode), .ack_n(ack_n), .data(m_data),
    .term_pull(m_pull)
  );

  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic do_reset();
    int n;
    rst_n = 1'b0;
    repeat (12) @(negedge clock);
    chk({bus_reset_n, req_ready, bus_clock_out, grant_n} === 4'b0001
      && stb_n === 16'hFFFF, "outputs in reset");
    rst_n = 1'b1;
    for (n = 0; n < 1000 && req_ready !== 1'b1; n++)
      @(negedge clock);
    chk(bus_reset_n === 1'b1 && req_ready === 1'b1, "reset end");
    if (req_ready !== 1'b1)
      end_of_test();
  endtask

  // Eight bus periods span 125 local cycles, give or take the jitter
  task automatic busclk();
    int n, r, t0;
    logic prev;
    r = 0;
    t0 = 0;
    prev = bus_clock_out;
    for (n = 0; n < 400 && r < 9; n++)
    begin
      @(negedge clock);
      if (bus_clock_out === 1'b1 && prev === 1'b0)
      begin
        r++;
        if (r == 1)
          t0 = n;
      end
      prev = bus_clock_out;
    end
    chk(r == 9 && n - 1 - t0 >= 124 && n - 1 - t0 <= 126, "bus rate");
    if (r != 9)
      end_of_test();
  endtask

  // Every cycle sample of an active strobe must match the request
  task automatic cyc(input mzc_space_t sp, input logic [1:0] sl,
      input logic [5:0] a, input logic wr, input logic [1:0] be,
      input logic [15:0] wd, input logic tmo, input logic term);
    logic rd;
    logic [15:0] act, exp_act, msk;
    int n;
    rd = !wr || sp == MZC_SP_ID || sp == MZC_SP_VEC;
    exp_act = 16'h0001 << (4 * int'(sp) + int'(sl));
    if (sp == MZC_SP_DMA)
      exp_act = 16'h0000;
    msk = {{8{be[1]}}, {8{be[0]}}};
    dma_slot = sl;
    req = '{sp, sl, a, wr, be, wd};
    req_valid = 1'b1;
    for (n = 0; n < 2000 && req_ready !== 1'b1; n++)
      @(negedge clock);
    if (req_ready !== 1'b1)
    begin
      chk(1'b0, "never ready");
      end_of_test();
    end
    @(negedge clock);
    req_valid = 1'b0;
    for (n = 0; n < 4000 && rsp_valid !== 1'b1; n++)
    begin
      act = ~stb_n;
      if (act != 16'h0000 || grant_n !== 1'b1)
      begin
        chk(act === exp_act && grant_n === (sp != MZC_SP_DMA), "strobe");
        chk(rnw === rd && addr === a, "direction or address");
        chk({be_hi_n, be_lo_n} === (rd ? 2'b00 : ~be), "byte enable");
        if (!rd)
          chk(d_oe_n === 1'b0 && ((d_o ^ wd) & msk) === 16'h0000, "wdata");
      end
      @(negedge clock);
    end
    if (rsp_valid !== 1'b1)
    begin
      chk(1'b0, "no answer");
      end_of_test();
    end
    chk({rsp.timeout, rsp.terminated, rsp.write} === {tmo, term, !rd}
      && d_oe_n === 1'b1, "answer status");
    if (rd && tmo)
      chk(rsp.rdata === 16'h0000, "timeout data");
    else if (rd && !term)
      chk(rsp.rdata === {4'hC, sl, sp[1:0], 2'h0, a}, "rdata");
  endtask

  task automatic term();
    dma_end_assert = 1'b1;
    @(negedge clock);
    chk(t_oe_n === 1'b0 && t_o === 1'b0, "terminate drive");
    repeat (4) @(negedge clock);
    chk(dma_end_seen === 1'b1, "terminate seen");
    dma_end_assert = 1'b0;
    repeat (5) @(negedge clock);
    chk(t_oe_n === 1'b1 && dma_end_seen === 1'b0, "terminate off");
  endtask

  task automatic status();
    dreq0 = 4'h5;
    dreq1 = 4'hA;
    svc0_n = 4'hC;
    svc1_n = 4'h3;
    err_n = 4'h6;
    repeat (4) @(negedge clock);
    chk(dma_pend0 === 4'h5 && dma_pend1 === 4'hA, "dma requests");
    chk(svc_req0 === 4'h3 && svc_req1 === 4'hC, "service");
    chk(fault === 4'h9, "fault");
  endtask

  initial
  begin
    @(negedge clock);
    do_reset();
    busclk();
    for (int s = 0; s < 4; s++)
      for (int p = 0; p < 4; p++)
        cyc(mzc_space_t'(p), 2'(s), 6'(p * 9 + s), 1'b0, 2'h3, 16'h0000, 1'b0, 1'b0);
    for (int b = 1; b < 4; b++)
      cyc(MZC_SP_MEM, 2'h1, 6'h3F, 1'b1, 2'(b), 16'hA55A, 1'b0, 1'b0);
    cyc(MZC_SP_IO, 2'h3, 6'h15, 1'b1, 2'h3, 16'h1234, 1'b0, 1'b0);
    cyc(MZC_SP_ID, 2'h0, 6'h01, 1'b1, 2'h3, 16'hFFFF, 1'b0, 1'b0);
    mute = 4'h4;
    cyc(MZC_SP_MEM, 2'h2, 6'h02, 1'b0, 2'h3, 16'h0000, 1'b1, 1'b0);
    cyc(MZC_SP_VEC, 2'h2, 6'h00, 1'b0, 2'h3, 16'h0000, 1'b1, 1'b0);
    mute = 4'h0;
    cyc(MZC_SP_DMA, 2'h1, 6'h0A, 1'b0, 2'h3, 16'h0000, 1'b0, 1'b0);
    term_mode = 1'b1;
    cyc(MZC_SP_DMA, 2'h2, 6'h0B, 1'b0, 2'h3, 16'h0000, 1'b0, 1'b1);
    term_mode = 1'b0;
    term();
    status();
    do_reset();
    cyc(MZC_SP_IO, 2'h0, 6'h20, 1'b0, 2'h3, 16'h0000, 1'b0, 1'b0);
    end_of_test();
  end
endmodule
